// *** design/acpf_cfg.svh ***
// Purpose: Constants of the command front end and power control.
// Assumes: 125 MHz internal oscillator clock.
// Notes: Times are kept in their own units; cycle counts derive from them.
`ifndef ACPF_CFG_SVH
`define ACPF_CFG_SVH
`define ACPF_CLK_NS 8
`define ACPF_WDT_MS 1000
`define ACPF_TMO_US 1000
`define ACPF_FLAG_SLEEP 8'h01
`define ACPF_FLAG_IDLE 8'h02
`define ACPF_FLAG_CMD 8'h03
`define ACPF_POS_COUNT 8'h00
`define ACPF_POS_OPCODE 8'h01
`define ACPF_POS_FIRST_PARAM 8'h02
`define ACPF_POS_SECOND_PARAM_LO 8'h03
`define ACPF_POS_SECOND_PARAM_HI 8'h04
`define ACPF_MIN_COUNT 8'h07
`define ACPF_CRC_POLY 16'h8005
`define ACPF_CRC_INIT 16'h0000
`define ACPF_ST_OK 8'h00
`define ACPF_ST_PARSE 8'h03
`define ACPF_ST_WAKE 8'h11
`define ACPF_ST_COMM 8'hff
`define ACPF_OP_KEY_DERIVE 8'h1c
`define ACPF_OP_REVISION 8'h30
`define ACPF_OP_DIGEST_GEN 8'h15
`define ACPF_OP_HMAC 8'h11
`define ACPF_OP_MAC_VERIFY 8'h28
`define ACPF_OP_LOCK 8'h17
`define ACPF_OP_MAC 8'h08
`define ACPF_OP_NONCE 8'h16
`define ACPF_OP_PAUSE 8'h01
`define ACPF_OP_RANDOM 8'h1b
`define ACPF_OP_READ 8'h02
`define ACPF_OP_SHA 8'h47
`define ACPF_OP_CFG_EXTRA 8'h20
`define ACPF_OP_WRITE 8'h12
`define ACPF_T_KEY_DERIVE_US 14000
`define ACPF_T_REVISION_US 400
`define ACPF_T_DIGEST_GEN_US 11000
`define ACPF_T_HMAC_US 27000
`define ACPF_T_MAC_VERIFY_US 12000
`define ACPF_T_LOCK_US 5000
`define ACPF_T_MAC_US 12000
`define ACPF_T_NONCE_US 22000
`define ACPF_T_PAUSE_US 400
`define ACPF_T_RANDOM_US 11000
`define ACPF_T_READ_US 400
`define ACPF_T_SHA_US 11000
`define ACPF_T_CFG_EXTRA_US 8000
`define ACPF_T_WRITE_US 4000
`endif

// *** design/acpf_pkg.sv ***
// Purpose: Types shared by the command front end modules.
// Assumes: Constants come from acpf_cfg.svh.
// Notes: Types only.
package acpf_pkg;
    typedef enum logic [1:0] {EV_WAKE, EV_START, EV_STOP, EV_BYTE} acpf_evk_t;
    typedef struct packed {
        acpf_evk_t kind;
        logic [7:0] data;
    } acpf_evt_t;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] first_param;
        logic [15:0] second_param;
    } acpf_cmd_t;
    typedef enum logic [2:0] {ST_SLEEP, ST_IDLE, ST_WAIT, ST_RECV, ST_BUSY} acpf_state_t;
    typedef enum logic [1:0] {PD_NONE, PD_SLEEP, PD_IDLE} acpf_pend_t;
    typedef struct packed {
        acpf_evt_t data;
        logic req;
        logic ack_m;
        logic ack_s;
    } acpf_lnk_st_t;
    typedef struct packed {
        logic req_m;
        logic req_s;
        logic req_p;
        logic ack;
        acpf_evt_t evt;
        logic vld;
    } acpf_sys_st_t;
endpackage

// *** design/acpf_link_cdc.sv ***
// Purpose: Carries link events from the link clock into the system clock.
// Assumes: Link clock may stop between frames; one event in flight at a time.
// Notes: Toggle handshake; events taken while busy are acknowledged and dropped.
`timescale 1ns/1ps
module acpf_link_cdc import acpf_pkg::*; (
    // Clocks and reset
    input wire logic sys_clk_i,
    input wire logic link_clk_i,
    input wire logic rst_i,
    // Link side
    input acpf_evt_t lnk_evt_i,
    input wire logic lnk_vld_i,
    output logic lnk_rdy_o,
    // System side
    input wire logic busy_i,
    output acpf_evt_t evt_o,
    output logic evt_vld_o
);
    acpf_lnk_st_t l_q, l_d;
    acpf_sys_st_t s_q, s_d;

    assign lnk_rdy_o = (l_q.req == l_q.ack_s);

    always_comb begin
        l_d = l_q;
        l_d.ack_m = s_q.ack;
        l_d.ack_s = l_q.ack_m;
        if (lnk_vld_i && lnk_rdy_o) begin
            l_d.data = lnk_evt_i;
            l_d.req = !l_q.req;
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.req_m = l_q.req;
        s_d.req_s = s_q.req_m;
        s_d.req_p = s_q.req_s;
        s_d.vld = 1'b0;
        if (s_q.req_s != s_q.req_p) begin
            s_d.evt = l_q.data;
            // Busy is judged on its own clock; a copy on a link clock that stops
            // between frames would go stale and drop the first byte after busy.
            s_d.vld = !busy_i;
            s_d.ack = s_q.req_s;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign evt_o = s_q.evt;
    assign evt_vld_o = s_q.vld;
endmodule

// *** design/acpf_buf.sv ***
// Purpose: Input block store for received packet bytes.
// Assumes: One write and one read port on the system clock.
// Notes: Read data is registered, one cycle after the address.
`timescale 1ns/1ps
module acpf_buf #(
    parameter int DW = 8,
    parameter int DEPTH = 128
) (
    // Clock
    input wire logic sys_clk_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// *** design/acpf_core.sv ***
// Purpose: Command framing, busy period and power states of the device.
// Assumes: A physical layer decodes wake, start, stop and bytes on link_clk_i.
// Notes: Algorithms are outside; this block frames, times and keeps volatile state.
// Contract
// - Address, sleep flag, Stop puts device to sleep and resets engine and buffers.
// - Address, word address 0x02, Stop puts the device into idle.
// - Explicit idle keeps temporary key and random seed.
// - Every entry into sleep clears volatile memory and status.
// - Temporary key copied by MAC verification is dropped on idle.
// - Watchdog starts on each accepted wake token.
// - Watchdog expiry forces sleep, even mid transfer or execution.
// - Watchdog restarts only by sleep or idle then wake.
// - Flag byte first, then count covering itself through CRC, not the flag.
// - Opcode, first param, two byte second param always present, then data.
// - Last two bytes are CRC-16, polynomial 0x8005, over count through data.
// - Full block makes device busy; no status readable until busy ends.
// - While busy the device ignores its data line.
// - Single-wire short packet sleeps after the byte timeout.
// - I2C short packet waits until watchdog, Start or Stop.
// - Wrong block size reaction is command specific: error or ignored bytes.
// - Opcodes 0x1c, 0x15, 0x11, 0x28, 0x08, 0x47 select the hash commands.
// - Opcodes 0x16, 0x1b, 0x17 and 0x30 return to wait; only 0x01 pauses into idle.
// - Opcodes 0x02 read, 0x12 write, 0x20 update configuration extra bytes.
// - After wake, before first command, status is 0x11.
// - CRC or communication error gives 0xff first, without execution.
`timescale 1ns/1ps
`include "acpf_cfg.svh"
module acpf_core import acpf_pkg::*; #(
    parameter int BUF_DEPTH = 128,
    parameter int WDT_CYCLES = (`ACPF_WDT_MS * 1000000) / `ACPF_CLK_NS,
    parameter int TMO_CYCLES = (`ACPF_TMO_US * 1000) / `ACPF_CLK_NS,
    parameter int CYC_PER_US = 1000 / `ACPF_CLK_NS
) (
    // Clocks and reset
    input wire logic sys_clk_i,
    input wire logic link_clk_i,
    input wire logic rst_i,
    // Interface select pin, high for single-wire
    input wire logic mode_swi_i,
    // Link events
    input acpf_evt_t lnk_evt_i,
    input wire logic lnk_vld_i,
    output logic lnk_rdy_o,
    // Command engine
    output logic exec_start_o,
    output acpf_cmd_t exec_cmd_o,
    output logic [7:0] exec_count_o,
    input wire logic [$clog2(BUF_DEPTH)-1:0] eng_rd_addr_i,
    output logic [7:0] eng_rd_data_o,
    input wire logic eng_tk_load_i,
    input wire logic eng_tk_copy_i,
    input wire logic eng_seed_load_i,
    // Status and power
    output logic rsp_valid_o,
    output logic [7:0] rsp_status_o,
    output logic busy_o,
    output logic sleep_o,
    output logic idle_o,
    output logic sram_clr_o,
    output logic tk_valid_o,
    output logic seed_valid_o
);
    localparam int AW = $clog2(BUF_DEPTH);

    typedef struct packed {
        acpf_state_t state;
        acpf_pend_t pend;
        logic swi_m;
        logic swi_s;
        logic [31:0] wdt;
        logic [31:0] tmo;
        logic [31:0] bsy;
        logic [7:0] idx;
        logic [7:0] cnt;
        logic [15:0] crc;
        logic [7:0] crc_lo;
        logic bad;
        acpf_cmd_t cmd;
        logic [7:0] status;
        logic [7:0] res;
        logic tk_valid;
        logic tk_copy;
        logic seed_valid;
        logic sram_clr;
        logic exec_start;
    } acpf_core_st_t;

    acpf_core_st_t q, d;
    acpf_evt_t evt;
    logic evt_vld;
    logic wr_en;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (b[i] ^ r[15]) begin
                r = {r[14:0], 1'b0} ^ `ACPF_CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Typical time in microseconds; zero marks an opcode that is not known.
    function automatic logic [31:0] exec_us(input logic [7:0] op);
        logic [31:0] t;
        t = 32'h0;
        case (op)
            `ACPF_OP_KEY_DERIVE: t = 32'(`ACPF_T_KEY_DERIVE_US);
            `ACPF_OP_DIGEST_GEN: t = 32'(`ACPF_T_DIGEST_GEN_US);
            `ACPF_OP_HMAC: t = 32'(`ACPF_T_HMAC_US);
            `ACPF_OP_MAC_VERIFY: t = 32'(`ACPF_T_MAC_VERIFY_US);
            `ACPF_OP_MAC: t = 32'(`ACPF_T_MAC_US);
            `ACPF_OP_SHA: t = 32'(`ACPF_T_SHA_US);
            `ACPF_OP_NONCE: t = 32'(`ACPF_T_NONCE_US);
            `ACPF_OP_RANDOM: t = 32'(`ACPF_T_RANDOM_US);
            `ACPF_OP_LOCK: t = 32'(`ACPF_T_LOCK_US);
            `ACPF_OP_REVISION: t = 32'(`ACPF_T_REVISION_US);
            `ACPF_OP_PAUSE: t = 32'(`ACPF_T_PAUSE_US);
            `ACPF_OP_READ: t = 32'(`ACPF_T_READ_US);
            `ACPF_OP_WRITE: t = 32'(`ACPF_T_WRITE_US);
            `ACPF_OP_CFG_EXTRA: t = 32'(`ACPF_T_CFG_EXTRA_US);
            default: t = 32'h0;
        endcase
        return t;
    endfunction

    acpf_link_cdc u_cdc (
        .sys_clk_i(sys_clk_i),
        .link_clk_i(link_clk_i),
        .rst_i(rst_i),
        .lnk_evt_i(lnk_evt_i),
        .lnk_vld_i(lnk_vld_i),
        .lnk_rdy_o(lnk_rdy_o),
        .busy_i(busy_o),
        .evt_o(evt),
        .evt_vld_o(evt_vld)
    );

    assign wr_en = evt_vld && evt.kind == EV_BYTE && q.state == ST_RECV
                   && q.idx < 8'(BUF_DEPTH);

    acpf_buf #(.DW(8), .DEPTH(BUF_DEPTH)) u_buf (
        .sys_clk_i(sys_clk_i),
        .wr_en_i(wr_en),
        .wr_addr_i(q.idx[AW-1:0]),
        .wr_data_i(evt.data),
        .rd_addr_i(eng_rd_addr_i),
        .rd_data_o(eng_rd_data_o)
    );

    always_comb begin
        d = q;
        d.swi_m = mode_swi_i;
        d.swi_s = q.swi_m;
        d.sram_clr = 1'b0;
        d.exec_start = 1'b0;
        if (eng_tk_load_i) begin
            d.tk_valid = 1'b1;
            d.tk_copy = 1'b0;
        end
        if (eng_tk_copy_i) begin
            d.tk_valid = 1'b1;
            d.tk_copy = 1'b1;
        end
        if (eng_seed_load_i) begin
            d.seed_valid = 1'b1;
        end
        if (q.state != ST_SLEEP && q.state != ST_IDLE) begin
            d.wdt = q.wdt + 32'h1;
        end
        case (q.state)
            ST_SLEEP, ST_IDLE: begin
                if (evt_vld && evt.kind == EV_WAKE) begin
                    d.state = ST_WAIT;
                    d.wdt = 32'h0;
                    d.status = `ACPF_ST_WAKE;
                    d.pend = PD_NONE;
                end
            end
            ST_WAIT: begin
                if (evt_vld && evt.kind == EV_STOP && q.pend == PD_SLEEP) begin
                    d.state = ST_SLEEP;
                end else if (evt_vld && evt.kind == EV_STOP && q.pend == PD_IDLE) begin
                    d.state = ST_IDLE;
                end else if (evt_vld && evt.kind != EV_BYTE) begin
                    d.pend = PD_NONE;
                end else if (evt_vld) begin
                    d.pend = PD_NONE;
                    if (evt.data == `ACPF_FLAG_CMD) begin
                        d.state = ST_RECV;
                        d.idx = 8'h0;
                        d.tmo = 32'h0;
                        d.crc = `ACPF_CRC_INIT;
                        d.bad = 1'b0;
                    end else if (evt.data == `ACPF_FLAG_SLEEP) begin
                        if (q.swi_s) begin
                            d.state = ST_SLEEP;
                        end else begin
                            d.pend = PD_SLEEP;
                        end
                    end else if (evt.data == `ACPF_FLAG_IDLE) begin
                        if (q.swi_s) begin
                            d.state = ST_IDLE;
                        end else begin
                            d.pend = PD_IDLE;
                        end
                    end
                end
            end
            ST_RECV: begin
                d.tmo = q.tmo + 32'h1;
                if (evt_vld && evt.kind == EV_BYTE) begin
                    d.tmo = 32'h0;
                    d.idx = q.idx + 8'h1;
                    case (q.idx)
                        `ACPF_POS_COUNT: begin
                            d.cnt = evt.data;
                            d.bad = evt.data < `ACPF_MIN_COUNT || evt.data > 8'(BUF_DEPTH);
                        end
                        `ACPF_POS_OPCODE: d.cmd.opcode = evt.data;
                        `ACPF_POS_FIRST_PARAM: d.cmd.first_param = evt.data;
                        `ACPF_POS_SECOND_PARAM_LO: d.cmd.second_param[7:0] = evt.data;
                        `ACPF_POS_SECOND_PARAM_HI: d.cmd.second_param[15:8] = evt.data;
                        default: d.cmd = q.cmd;
                    endcase
                    if (q.idx + 8'h2 < d.cnt) begin
                        d.crc = crc_step(q.crc, evt.data);
                    end else if (q.idx + 8'h2 == d.cnt) begin
                        d.crc_lo = evt.data;
                    end
                    // A count below ACPF_MIN_COUNT or above BUF_DEPTH is bad; end it at once.
                    if (q.idx + 8'h1 == d.cnt || d.bad) begin
                        d.state = ST_BUSY;
                        d.bsy = 32'h1;
                        if (d.bad || {evt.data, q.crc_lo} != q.crc) begin
                            d.res = `ACPF_ST_COMM;
                        end else if (exec_us(q.cmd.opcode) == 32'h0) begin
                            d.res = `ACPF_ST_PARSE;
                        end else begin
                            d.res = `ACPF_ST_OK;
                            d.bsy = exec_us(q.cmd.opcode) * 32'(CYC_PER_US);
                            d.exec_start = 1'b1;
                        end
                    end
                end else if (evt_vld && !q.swi_s) begin
                    d.state = ST_WAIT;
                    d.status = `ACPF_ST_COMM;
                end else if (q.swi_s && q.tmo >= 32'(TMO_CYCLES)) begin
                    d.state = ST_SLEEP;
                end
            end
            ST_BUSY: begin
                d.bsy = q.bsy - 32'h1;
                if (q.bsy <= 32'h1) begin
                    d.status = q.res;
                    d.state = ST_WAIT;
                    if (q.res == `ACPF_ST_OK && q.cmd.opcode == `ACPF_OP_PAUSE) begin
                        d.state = ST_IDLE;
                    end
                end
            end
            default: d.state = ST_SLEEP;
        endcase
        if (q.state != ST_SLEEP && q.state != ST_IDLE && q.wdt >= 32'(WDT_CYCLES)) begin
            d.state = ST_SLEEP;
            d.exec_start = 1'b0;
        end
        if (d.state == ST_SLEEP && q.state != ST_SLEEP) begin
            d.tk_valid = 1'b0;
            d.tk_copy = 1'b0;
            d.seed_valid = 1'b0;
            d.status = `ACPF_ST_OK;
            d.res = `ACPF_ST_OK;
            d.cmd = '0;
            d.idx = 8'h0;
            d.pend = PD_NONE;
            d.sram_clr = 1'b1;
        end
        if (d.state == ST_IDLE && q.state != ST_IDLE && q.tk_copy) begin
            d.tk_valid = 1'b0;
            d.tk_copy = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy_o = (q.state == ST_BUSY);
    assign sleep_o = (q.state == ST_SLEEP);
    assign idle_o = (q.state == ST_IDLE);
    assign rsp_valid_o = (q.state == ST_WAIT);
    assign rsp_status_o = q.status;
    assign exec_start_o = q.exec_start;
    assign exec_cmd_o = q.cmd;
    assign exec_count_o = q.cnt;
    assign sram_clr_o = q.sram_clr;
    assign tk_valid_o = q.tk_valid;
    assign seed_valid_o = q.seed_valid;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    wdt_expiry_a: assert property (
        (q.state inside {ST_WAIT, ST_RECV, ST_BUSY} && q.wdt >= 32'(WDT_CYCLES))
        |=> sleep_o && sram_clr_o)
        else $error("Watchdog expiry did not force sleep.");
    wake_status_a: assert property (
        ((sleep_o || idle_o) && evt_vld && evt.kind == EV_WAKE)
        |=> rsp_valid_o && rsp_status_o == `ACPF_ST_WAKE && q.wdt == 32'h0)
        else $error("Wake did not load the wake status.");
    sleep_clear_a: assert property (
        $rose(sleep_o) |-> !tk_valid_o && !seed_valid_o && rsp_status_o == `ACPF_ST_OK)
        else $error("Sleep entry left volatile state.");
    idle_keep_a: assert property (
        ($rose(idle_o) && $past(seed_valid_o) && !$past(eng_seed_load_i)) |-> seed_valid_o)
        else $error("Idle lost the random seed.");
    idle_copy_a: assert property (
        (q.state != ST_IDLE && d.state == ST_IDLE && q.tk_copy) |=> !tk_valid_o)
        else $error("Copied temporary key survived idle.");
    busy_mute_a: assert property (
        busy_o |-> !rsp_valid_o)
        else $error("Status readable while busy.");
    crc_error_a: assert property (
        (q.state == ST_BUSY && q.res == `ACPF_ST_COMM) |-> !exec_start_o && q.bsy <= 32'h1)
        else $error("Communication error went to execution.");
    idle_seq_a: assert property (
        (q.state == ST_WAIT && q.pend == PD_IDLE && evt_vld && evt.kind == EV_STOP
         && q.wdt < 32'(WDT_CYCLES)) |=> idle_o)
        else $error("Idle sequence did not reach idle.");
    busy_len_a: assert property (
        (exec_start_o && busy_o) |-> q.bsy == exec_us(exec_cmd_o.opcode) * 32'(CYC_PER_US))
        else $error("Busy period does not match the opcode.");
    swi_timeout_a: assert property (
        (q.state == ST_RECV && q.swi_s && !evt_vld && q.tmo >= 32'(TMO_CYCLES)) |=> sleep_o)
        else $error("Single-wire short packet did not time out to sleep.");
endmodule

// *** bench/acpf_host_model.sv ***
// Purpose: Host model that makes the link clock and offers link events.
// Assumes: The link clock runs only while an event is handed over.
// Notes: Released data shows the inverse of the last byte, so no stale copy can pass.
`timescale 1ns/1ps
module acpf_host_model import acpf_pkg::*; (
    // Link side
    output logic link_clk_o,
    input wire logic lnk_rdy_i,
    output acpf_evt_t evt_o,
    output logic vld_o
);
    logic run = 1'b0;
    int n;
    initial begin
        link_clk_o = 1'b0;
        vld_o = 1'b0;
        evt_o = '{EV_BYTE, 8'h00};
        #13.7;
        forever #32 if (run || link_clk_o) link_clk_o = ~link_clk_o;
    end
    // The event stands from a falling edge through the rising edge that takes it.
    task automatic send(input acpf_evk_t k, input logic [7:0] d);
        run = 1'b1;
        n = 0;
        @(negedge link_clk_o);
        while (!lnk_rdy_i && n < 64) begin
            @(negedge link_clk_o);
            n++;
        end
        evt_o = '{k, d};
        vld_o = 1'b1;
        @(negedge link_clk_o);
        vld_o = 1'b0;
        evt_o.data = ~d;
        n = 0;
        while (!lnk_rdy_i && n < 64) begin
            @(negedge link_clk_o);
            n++;
        end
        run = 1'b0;
    endtask
endmodule

// *** bench/test_auth_command_power_frontend.sv ***
// Purpose: Self-checking bench of the command front end and power control.
// Assumes: Short watchdog and timeout counts; one microsecond is one cycle.
// Notes: Only short commands run, since longer ones would outlast the watchdog.
`timescale 1ns/1ps
`include "acpf_cfg.svh"
module test_auth_command_power_frontend import acpf_pkg::*; ;
    localparam int WDT = 4000;
    localparam int TMO = 200;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mode_swi = 1'b0;
    logic link_clk, lnk_vld, lnk_rdy, exec_start, rsp_valid, busy, sleep, idle, sram_clr;
    logic tk_load = 1'b0, tk_copy = 1'b0, seed_load = 1'b0, tk_valid, seed_valid;
    logic [6:0] rd_addr = 7'h00;
    logic [7:0] rd_data, exec_count, rsp_status;
    acpf_evt_t lnk_evt;
    acpf_cmd_t exec_cmd;
    int err_total = 0, num_checks = 0, cyc = 0, n_start = 0, n_clr = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    acpf_host_model host (.link_clk_o(link_clk), .lnk_rdy_i(lnk_rdy), .evt_o(lnk_evt),
        .vld_o(lnk_vld));
    acpf_core #(.WDT_CYCLES(WDT), .TMO_CYCLES(TMO), .CYC_PER_US(1)) DUT (
        .sys_clk_i(sys_clk_i), .link_clk_i(link_clk), .rst_i(rst_i), .mode_swi_i(mode_swi),
        .lnk_evt_i(lnk_evt), .lnk_vld_i(lnk_vld), .lnk_rdy_o(lnk_rdy),
        .exec_start_o(exec_start), .exec_cmd_o(exec_cmd), .exec_count_o(exec_count),
        .eng_rd_addr_i(rd_addr), .eng_rd_data_o(rd_data), .eng_tk_load_i(tk_load),
        .eng_tk_copy_i(tk_copy), .eng_seed_load_i(seed_load), .rsp_valid_o(rsp_valid),
        .rsp_status_o(rsp_status), .busy_o(busy), .sleep_o(sleep), .idle_o(idle),
        .sram_clr_o(sram_clr), .tk_valid_o(tk_valid), .seed_valid_o(seed_valid));
    always @(posedge sys_clk_i) begin
        cyc++;
        n_start += (exec_start === 1'b1);
        n_clr += (sram_clr === 1'b1);
        if (cyc == 40000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_byte({7'h00, got}, {7'h00, exp}, m);
    endtask
    // Waits on rsp_valid (0), sleep (1) or idle (2), counting cycles.
    task automatic wait_st(input int w, input int lim, output int el);
        logic [2:0] v;
        el = 0;
        v = {idle, sleep, rsp_valid};
        while (v[w] !== 1'b1 && el < lim) begin
            @(negedge sys_clk_i);
            el++;
            v = {idle, sleep, rsp_valid};
        end
    endtask
    task automatic pulse(input int which);
        @(negedge sys_clk_i);
        {seed_load, tk_copy, tk_load} = 3'b001 << which;
        @(negedge sys_clk_i);
        {seed_load, tk_copy, tk_load} = 3'b000;
        @(negedge sys_clk_i);
    endtask
    task automatic cmd(input logic [7:0] op, input logic bad);
        logic [7:0] b [5];
        logic [15:0] c;
        b = '{8'h07, op, 8'h5a, 8'h34, 8'h12};
        c = `ACPF_CRC_INIT;
        foreach (b[i]) for (int j = 0; j < 8; j++) begin
            c = {c[14:0], 1'b0} ^ (((b[i][j] ^ c[15]) === 1'b1) ? `ACPF_CRC_POLY : 16'h0000);
        end
        host.send(EV_BYTE, `ACPF_FLAG_CMD);
        foreach (b[i]) host.send(EV_BYTE, b[i]);
        host.send(EV_BYTE, c[7:0] ^ {7'h00, bad});
        host.send(EV_BYTE, c[15:8]);
    endtask
    task automatic t_wake();
        int el;
        host.send(EV_WAKE, 8'h00);
        wait_st(0, 300, el);
        chk_byte(rsp_status, `ACPF_ST_WAKE, "wake status");
        chk_bit(sleep, 1'b0, "awake");
    endtask
    task automatic t_cmd(input logic [7:0] op, input logic bad, input logic [7:0] st, int run);
        int s0, el;
        s0 = n_start;
        cmd(op, bad);
        if (run > 1) begin
            chk_bit(rsp_valid, 1'b0, "hidden while busy");
            chk_bit(busy, 1'b1, "busy");
            chk_byte(exec_cmd.second_param[15:8], 8'h12, "second_param high");
            chk_byte(exec_cmd.opcode, op, "opcode");
            chk_byte(exec_cmd.first_param, 8'h5a, "first_param");
            chk_byte(exec_cmd.second_param[7:0], 8'h34, "second_param low");
            chk_byte(exec_count, 8'h07, "count");
            @(negedge sys_clk_i);
            @(negedge sys_clk_i);
            chk_byte(rd_data, 8'h07, "stored count");
            host.send(EV_BYTE, `ACPF_FLAG_SLEEP);
        end
        wait_st(0, 2000, el);
        chk_byte(rsp_status, st, "status");
        chk_byte(8'(n_start - s0), {7'h00, run > 1}, "starts");
        if (run > 1) chk_bit(el > run - 150 && el <= run, 1'b1, "busy time");
        $display("done command %h", op);
    endtask
    task automatic t_power();
        int el, s0;
        pulse(2);
        pulse(1);
        chk_bit(seed_valid & tk_valid, 1'b1, "loaded");
        host.send(EV_BYTE, `ACPF_FLAG_IDLE);
        host.send(EV_STOP, 8'h00);
        wait_st(2, 300, el);
        chk_bit(idle, 1'b1, "idle");
        chk_bit(seed_valid, 1'b1, "seed kept");
        chk_bit(tk_valid, 1'b0, "copied key dropped");
        t_wake();
        pulse(0);
        s0 = n_clr;
        host.send(EV_BYTE, `ACPF_FLAG_SLEEP);
        host.send(EV_STOP, 8'h00);
        wait_st(1, 300, el);
        chk_bit(sleep, 1'b1, "sleep");
        chk_byte(8'(n_clr - s0), 8'h01, "memory clear");
        chk_bit(seed_valid | tk_valid, 1'b0, "state cleared");
        $display("done idle and sleep");
    endtask
    task automatic t_short(input logic swi, input logic stop);
        int el;
        @(negedge sys_clk_i);
        mode_swi = swi;
        t_wake();
        host.send(EV_BYTE, `ACPF_FLAG_CMD);
        host.send(EV_BYTE, 8'h07);
        if (stop) begin
            host.send(EV_STOP, 8'h00);
            wait_st(0, 300, el);
            chk_byte(rsp_status, `ACPF_ST_COMM, "cut packet");
        end else begin
            wait_st(1, swi ? TMO : WDT, el);
            chk_bit(sleep, 1'b1, "forced sleep");
            chk_bit(el > (swi ? TMO - 90 : WDT - 300), 1'b1, "not early");
        end
        mode_swi = 1'b0;
        $display("done short packet");
    endtask
    task automatic t_pause();
        int el;
        cmd(`ACPF_OP_PAUSE, 1'b0);
        wait_st(2, 900, el);
        chk_bit(idle, 1'b1, "pause to idle");
        $display("done pause");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk_bit(sleep & lnk_rdy & ~busy, 1'b1, "reset state");
        rst_i = 1'b0;
        t_wake();
        t_cmd(`ACPF_OP_REVISION, 1'b0, `ACPF_ST_OK, `ACPF_T_REVISION_US);
        t_cmd(`ACPF_OP_READ, 1'b0, `ACPF_ST_OK, `ACPF_T_READ_US);
        t_cmd(`ACPF_OP_READ, 1'b1, `ACPF_ST_COMM, 1);
        t_cmd(8'h55, 1'b0, `ACPF_ST_PARSE, 1);
        t_power();
        t_short(1'b0, 1'b0);
        t_short(1'b1, 1'b0);
        t_short(1'b0, 1'b1);
        t_pause();
        give_verdict();
    end
endmodule
